/* port_regs_defines.svh */
`ifndef PORT_REGS_DEFINES_SVH
`define PORT_REGS_DEFINES_SVH

// register byte addresses are four times the word index
`define DEV_STATUS_INDEX    12'h004a
`define LINK_CAP_INDEX      12'h004c
`define DEV_STATUS_ADDR     14'h0128
`define LINK_CAP_ADDR       14'h0130
`define IRQ_MASK_ADDR       14'h0200
`define WIDTH_DEFAULT_ADDR  14'h0204

// status fields
`define STS_CORR_BIT        0
`define STS_NONFATAL_BIT    1
`define STS_FATAL_BIT       2
`define STS_UNSUP_BIT       3
`define STS_FLAG_COUNT      4
`define STS_FLAG_MSB        3

// link capability fields
`define CAP_SPEED_LSB       0
`define CAP_SPEED_MSB       3
`define CAP_WIDTH_LSB       4
`define CAP_WIDTH_MSB       9
`define CAP_ASPM_LSB        10
`define CAP_ASPM_MSB        11
`define CAP_L0S_LSB         12
`define CAP_L0S_MSB         14

// field values
`define SPEED_5G            4'h2
`define ASPM_RESET          2'h3
`define L0S_RESET           3'h6
`define WIDTH_X1            6'h01
`define WIDTH_X2            6'h02
`define WIDTH_X4            6'h04
`define WIDTH_X8            6'h08
`define WIDTH_X12           6'h0c
`define WIDTH_X16           6'h0d
`define WIDTH_X32           6'h20

// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* port_regs_pkg.sv */
package port_regs_pkg;
   typedef logic [31:0] word_type;
   typedef logic [13:0] addr_type;
   typedef logic [5:0]  width_code_type;
   typedef enum logic [1:0] {
      port_disabled,
      port_active,
      port_loopback
   } port_mode_type;
endpackage

/* pcie_port_dev_status_link_cap.sv */
`timescale 1ns/10ps
`include "port_regs_defines.svh"

// Functional notes
// - correctable error sets status bit 0 always; write one clears it
// - non-fatal error sets status bit 1 always; write one clears it
// - fatal error sets status bit 2 always; write one clears it
// - unsupported request sets status bit 3 always; write one clears it
// - aux power present bit 4 reads zero, writes ignored
// - pending transactions bit 5 reads zero
// - max speed field bits 3:0 read-only, reads 0x2 (5 Gbps)
// - max width field bits 9:4 holds lane count, strap default
// - software may write max width to force narrower training
// - invalid width code is stored; port runs at default width
// - hardware never alters the written width value
// - width write outside disabled mode triggers immediate link retrain
// - receiver errors during such retrain may log as correctable
// - aspm support bits 11:10 reset 0x3, software writable
// - l0s exit latency bits 14:12 reset 0x6
module pcie_port_dev_status_link_cap (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire port_regs_pkg::addr_type       s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire port_regs_pkg::word_type       s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire port_regs_pkg::addr_type       s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output port_regs_pkg::word_type            s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          correctable_err_evt,
   input  wire logic                          nonfatal_err_evt,
   input  wire logic                          fatal_err_evt,
   input  wire logic                          unsupported_req_evt,
   input  wire port_regs_pkg::width_code_type strap_width,
   input  wire port_regs_pkg::port_mode_type  port_mode,
   input  wire logic                          phy_receiver_err,
   input  wire logic                          phy_retraining,
   output logic                               retrain_req,
   output port_regs_pkg::width_code_type      operating_width,
   output logic [1:0]                         power_state_support,
   output logic                               adv_err_rx_err_log,
   output logic                               irq
);
   import port_regs_pkg::*;

   function automatic logic width_code_valid(input width_code_type c);
      width_code_valid = (c == `WIDTH_X1) || (c == `WIDTH_X2) || (c == `WIDTH_X4) ||
                         (c == `WIDTH_X8) || (c == `WIDTH_X12) || (c == `WIDTH_X16) ||
                         (c == `WIDTH_X32);
   endfunction

   // widest byte lane mask helper: a field is written only when all its lanes are enabled
   function automatic logic lanes_on(input logic [3:0] strb, input int lo, input int hi);
      logic ok;
      ok = 1'b1;
      for (int b = 0; b < 4; b++) begin
         if ((b * 8 + 7 >= lo) && (b * 8 <= hi) && !strb[b]) begin
            ok = 1'b0;
         end
      end
      lanes_on = ok;
   endfunction

   // write channel state
   logic                       aw_held_reg;
   addr_type                   aw_addr_reg;
   logic                       w_held_reg;
   word_type                   w_data_reg;
   logic [3:0]                 w_strb_reg;
   logic                       bvalid_reg;
   logic [1:0]                 bresp_reg;
   logic                       do_write;
   // read channel state
   logic                       rvalid_reg;
   word_type                   rdata_reg;
   logic [1:0]                 rresp_reg;
   logic                       do_read;
   // registers
   logic [`STS_FLAG_MSB:0]     err_flags_reg;
   logic [`STS_FLAG_MSB:0]     irq_mask_reg;
   width_code_type             max_width_reg;
   width_code_type             width_default_reg;
   logic [1:0]                 aspm_reg;
   logic [2:0]                 l0s_reg;
   logic                       width_loaded_reg;
   logic                       retrain_reg;
   logic                       retrain_window_reg;
   logic                       rx_log_reg;
   logic [`STS_FLAG_MSB:0]     err_events;
   logic [`STS_FLAG_MSB:0]     clear_mask;
   logic [`STS_FLAG_MSB:0]     read_clear;
   logic [15:0]                status_word;
   word_type                   cap_word;
   word_type                   read_word;
   logic                       read_hit;
   logic                       write_hit;
   logic                       wr_status;
   logic                       wr_cap;

   assign err_events = {unsupported_req_evt, fatal_err_evt, nonfatal_err_evt,
                        correctable_err_evt};

   // ---------------- write channel ----------------
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   always_comb begin
      write_hit = 1'b1;
      unique case (aw_addr_reg)
         `DEV_STATUS_ADDR, `LINK_CAP_ADDR, `IRQ_MASK_ADDR, `WIDTH_DEFAULT_ADDR: begin
            write_hit = 1'b1;
         end
         default: begin
            write_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign wr_status = do_write && (aw_addr_reg == `DEV_STATUS_ADDR);
   assign wr_cap    = do_write && (aw_addr_reg == `LINK_CAP_ADDR);

   // ---------------- status flags ----------------
   // only the low lane holds the flags; bits 15:4 are never stored
   assign clear_mask = (wr_status && w_strb_reg[0]) ?
                       w_data_reg[`STS_FLAG_MSB:0] : '0;
   assign read_clear = (do_read && (s_axi_araddr == `DEV_STATUS_ADDR)) ?
                       err_flags_reg : '0;

   // set wins over clear so an event in the clearing cycle survives
   generate
      for (genvar i = 0; i < `STS_FLAG_COUNT; i++) begin : g_flag
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               err_flags_reg[i] <= 1'b0;
            end else if (err_events[i]) begin
               err_flags_reg[i] <= 1'b1;
            end else if (clear_mask[i] || read_clear[i]) begin
               err_flags_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // aux power and pending transactions are constant zero
   assign status_word = {12'h0000, err_flags_reg};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_reg <= '0;
      end else if (do_write && (aw_addr_reg == `IRQ_MASK_ADDR) && w_strb_reg[0]) begin
         irq_mask_reg <= w_data_reg[`STS_FLAG_MSB:0];
      end
   end

   assign irq = |(err_flags_reg & irq_mask_reg);

   // ---------------- link capabilities ----------------
   // strap is caught on the first clock after reset release, not under reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         width_loaded_reg  <= 1'b0;
         width_default_reg <= `WIDTH_X1;
         max_width_reg     <= `WIDTH_X1;
      end else if (!width_loaded_reg) begin
         width_loaded_reg  <= 1'b1;
         width_default_reg <= strap_width;
         max_width_reg     <= strap_width;
      end else if (wr_cap && lanes_on(w_strb_reg, `CAP_WIDTH_LSB, `CAP_WIDTH_MSB)) begin
         max_width_reg <= w_data_reg[`CAP_WIDTH_MSB:`CAP_WIDTH_LSB];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aspm_reg <= `ASPM_RESET;
         l0s_reg  <= `L0S_RESET;
      end else if (wr_cap && w_strb_reg[1]) begin
         aspm_reg <= w_data_reg[`CAP_ASPM_MSB:`CAP_ASPM_LSB];
         l0s_reg  <= w_data_reg[`CAP_L0S_MSB:`CAP_L0S_LSB];
      end
   end

   assign cap_word = {17'h0_0000, l0s_reg, aspm_reg, max_width_reg, `SPEED_5G};

   // invalid codes and widenings fall back to the strapped width
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         operating_width <= `WIDTH_X1;
      end else if (width_code_valid(max_width_reg) &&
                   (max_width_reg <= width_default_reg)) begin
         operating_width <= max_width_reg;
      end else begin
         operating_width <= width_default_reg;
      end
   end

   assign power_state_support = aspm_reg;

   // one-cycle pulse to the training machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         retrain_reg <= 1'b0;
      end else begin
         retrain_reg <= wr_cap && lanes_on(w_strb_reg, `CAP_WIDTH_LSB, `CAP_WIDTH_MSB) &&
                        (port_mode != port_disabled);
      end
   end

   assign retrain_req = retrain_reg;

   // receiver errors are forwarded only while a width retrain is in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         retrain_window_reg <= 1'b0;
      end else if (retrain_reg) begin
         retrain_window_reg <= 1'b1;
      end else if (!phy_retraining) begin
         retrain_window_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_log_reg <= 1'b0;
      end else begin
         rx_log_reg <= phy_receiver_err && (retrain_window_reg || retrain_reg);
      end
   end

   assign adv_err_rx_err_log = rx_log_reg;

   // ---------------- read channel ----------------
   assign s_axi_arready = !rvalid_reg;
   assign do_read       = s_axi_arvalid && s_axi_arready;

   always_comb begin
      read_hit  = 1'b1;
      read_word = '0;
      unique case (s_axi_araddr)
         `DEV_STATUS_ADDR: begin
            read_word = {16'h0000, status_word};
         end
         `LINK_CAP_ADDR: begin
            read_word = cap_word;
         end
         `IRQ_MASK_ADDR: begin
            read_word = {28'h000_0000, irq_mask_reg};
         end
         `WIDTH_DEFAULT_ADDR: begin
            read_word = {26'h000_0000, width_default_reg};
         end
         default: begin
            read_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= `RESP_OKAY;
      end else if (do_read) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= read_word;
         rresp_reg  <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

   // ---------------- assertions ----------------
   a_corr_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      correctable_err_evt |=> err_flags_reg[`STS_CORR_BIT])
      else $error("correctable flag not set");
   a_nonfatal_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      nonfatal_err_evt |=> err_flags_reg[`STS_NONFATAL_BIT])
      else $error("nonfatal flag not set");
   a_fatal_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      fatal_err_evt |=> err_flags_reg[`STS_FATAL_BIT])
      else $error("fatal flag not set");
   a_unsup_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      unsupported_req_evt |=> err_flags_reg[`STS_UNSUP_BIT])
      else $error("unsupported flag not set");
   a_w1c_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      (clear_mask[0] && !correctable_err_evt) |=> !err_flags_reg[0])
      else $error("write one did not clear");
   a_zero_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
      (err_flags_reg[1] && !clear_mask[1] && !read_clear[1]) |=> err_flags_reg[1])
      else $error("flag lost without clear");
   a_status_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      (rvalid_reg && $past(do_read) && ($past(s_axi_araddr) == `DEV_STATUS_ADDR))
      |-> (rdata_reg[31:4] == 28'h000_0000))
      else $error("status high bits not zero");
   a_speed_const: assert property (@(posedge aclk) disable iff (!aresetn)
      (rvalid_reg && $past(do_read) && ($past(s_axi_araddr) == `LINK_CAP_ADDR))
      |-> (rdata_reg[`CAP_SPEED_MSB:`CAP_SPEED_LSB] == `SPEED_5G))
      else $error("speed field changed");
   a_width_kept: assert property (@(posedge aclk) disable iff (!aresetn)
      (width_loaded_reg && !wr_cap) |=> $stable(max_width_reg))
      else $error("width field altered by hardware");
   a_retrain_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_cap && w_strb_reg[0] && w_strb_reg[1] && port_mode != port_disabled)
      |=> retrain_req ##1 !retrain_req)
      else $error("missing retrain pulse");
   a_no_retrain_dis: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_cap && port_mode == port_disabled) |=> !retrain_req)
      else $error("retrain while disabled");
   a_invalid_default: assert property (@(posedge aclk) disable iff (!aresetn)
      (width_loaded_reg && !width_code_valid(max_width_reg))
      |=> operating_width == $past(width_default_reg))
      else $error("invalid width not defaulted");

   c_error_logged: cover property (@(posedge aclk) disable iff (!aresetn)
      fatal_err_evt ##1 irq);
   c_clear_race: cover property (@(posedge aclk) disable iff (!aresetn)
      clear_mask[0] && correctable_err_evt);
   c_width_retrain: cover property (@(posedge aclk) disable iff (!aresetn)
      retrain_req ##[1:20] adv_err_rx_err_log);
   c_bad_address: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);

endmodule

/* tb.sv */
`timescale 1ns/10ps
`include "port_regs_defines.svh"
`define CHK(got, exp) begin \
   checked = checked + 1; \
   if ((got) !== (exp)) begin \
      n_fail = n_fail + 1; \
      $display("BAD %0t got %h want %h", $time, got, exp); \
   end \
end

module tb;
   import port_regs_pkg::*;

   localparam int LIMIT = 20000;

   logic           aclk;
   logic           aresetn;
   addr_type       s_axi_awaddr;
   logic           s_axi_awvalid;
   logic           s_axi_awready;
   word_type       s_axi_wdata;
   logic [3:0]     s_axi_wstrb;
   logic           s_axi_wvalid;
   logic           s_axi_wready;
   logic [1:0]     s_axi_bresp;
   logic           s_axi_bvalid;
   logic           s_axi_bready;
   addr_type       s_axi_araddr;
   logic           s_axi_arvalid;
   logic           s_axi_arready;
   word_type       s_axi_rdata;
   logic [1:0]     s_axi_rresp;
   logic           s_axi_rvalid;
   logic           s_axi_rready;
   logic           correctable_err_evt;
   logic           nonfatal_err_evt;
   logic           fatal_err_evt;
   logic           unsupported_req_evt;
   width_code_type strap_width;
   port_mode_type  port_mode;
   logic           phy_receiver_err;
   logic           phy_retraining;
   logic           retrain_req;
   width_code_type operating_width;
   logic [1:0]     power_state_support;
   logic           adv_err_rx_err_log;
   logic           irq;
   int             n_fail;
   int             checked;
   int             cycles;
   int             n_retrain;
   int             n_rxlog;

   pcie_port_dev_status_link_cap dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .correctable_err_evt(correctable_err_evt), .nonfatal_err_evt(nonfatal_err_evt),
      .fatal_err_evt(fatal_err_evt), .unsupported_req_evt(unsupported_req_evt),
      .strap_width(strap_width), .port_mode(port_mode), .phy_receiver_err(phy_receiver_err),
      .phy_retraining(phy_retraining), .retrain_req(retrain_req),
      .operating_width(operating_width), .power_state_support(power_state_support),
      .adv_err_rx_err_log(adv_err_rx_err_log), .irq(irq)
   );

   initial aclk = 1'b0;
   always #25 aclk = ~aclk;

   // pulses counted at the edge so a one-cycle output is never missed
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (retrain_req === 1'b1) n_retrain = n_retrain + 1;
      if (adv_err_rx_err_log === 1'b1) n_rxlog = n_rxlog + 1;
      if (cycles == LIMIT) begin
         n_fail = n_fail + 1;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // settle past the edge before looking at levels
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask

   task automatic axi_write(input addr_type a, input word_type d, input logic [3:0] s,
                            output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input addr_type a, output word_type d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rd_chk(input addr_type a, input word_type exp);
      word_type   d;
      logic [1:0] r;
      axi_read(a, d, r);
      `CHK(r, `RESP_OKAY)
      `CHK(d, exp)
   endtask

   task automatic wr_ok(input addr_type a, input word_type d);
      logic [1:0] r;
      axi_write(a, d, 4'hf, r);
      `CHK(r, `RESP_OKAY)
   endtask

   function automatic word_type cap_word(input width_code_type w, input logic [1:0] a);
      return {17'h0_0000, `L0S_RESET, a, w, `SPEED_5G};
   endfunction

   task automatic set_evts(input logic [3:0] v);
      correctable_err_evt <= v[0];
      nonfatal_err_evt <= v[1];
      fatal_err_evt <= v[2];
      unsupported_req_evt <= v[3];
   endtask

   task automatic t_reset_values();
      rd_chk(`LINK_CAP_ADDR, cap_word(`WIDTH_X8, `ASPM_RESET));
      rd_chk(`DEV_STATUS_ADDR, 32'h0000_0000);
      `CHK(operating_width, `WIDTH_X8)
      `CHK(power_state_support, `ASPM_RESET)
      rd_chk(`WIDTH_DEFAULT_ADDR, 32'h0000_0008);
      `CHK(irq, 1'b0)
   endtask

   task automatic t_events();
      for (int i = 0; i < 4; i++) begin
         @(posedge aclk);
         set_evts(4'h1 << i);
         @(posedge aclk);
         set_evts(4'h0);
         rd_chk(`DEV_STATUS_ADDR, 32'h0000_0001 << i);
      end
   endtask

   task automatic t_w1c();
      @(posedge aclk);
      set_evts(4'hf);
      @(posedge aclk);
      set_evts(4'h0);
      // ones into read-only and reserved bits must not stick
      wr_ok(`DEV_STATUS_ADDR, 32'hffff_fff5);
      rd_chk(`DEV_STATUS_ADDR, 32'h0000_000a);
      rd_chk(`DEV_STATUS_ADDR, 32'h0000_0000);
      @(posedge aclk);
      set_evts(4'h1);
      wr_ok(`DEV_STATUS_ADDR, 32'h0000_0001);
      set_evts(4'h0);
      rd_chk(`DEV_STATUS_ADDR, 32'h0000_0001);
   endtask

   task automatic t_irq();
      wr_ok(`IRQ_MASK_ADDR, 32'h0000_0000);
      @(posedge aclk);
      set_evts(4'h4);
      @(posedge aclk);
      set_evts(4'h0);
      wait_cyc(2);
      `CHK(irq, 1'b0)
      wr_ok(`IRQ_MASK_ADDR, 32'h0000_0004);
      wait_cyc(1);
      `CHK(irq, 1'b1)
      rd_chk(`IRQ_MASK_ADDR, 32'h0000_0004);
      rd_chk(`DEV_STATUS_ADDR, 32'h0000_0004);
      wait_cyc(1);
      `CHK(irq, 1'b0)
   endtask

   task automatic pulse_rx();
      phy_receiver_err <= 1'b1;
      @(posedge aclk);
      phy_receiver_err <= 1'b0;
      wait_cyc(3);
   endtask

   task automatic t_width();
      logic [1:0] r;
      port_mode <= port_disabled;
      wr_ok(`LINK_CAP_ADDR, cap_word(`WIDTH_X2, `ASPM_RESET) | 32'hffff_800f);
      pulse_rx();
      `CHK(n_retrain, 0)
      `CHK(n_rxlog, 0)
      `CHK(operating_width, `WIDTH_X2)
      @(posedge aclk);
      port_mode <= port_active;
      phy_retraining <= 1'b1;
      wr_ok(`LINK_CAP_ADDR, cap_word(`WIDTH_X4, 2'h1) | 32'hffff_800f);
      pulse_rx();
      @(posedge aclk);
      phy_retraining <= 1'b0;
      `CHK(n_retrain, 1)
      `CHK(n_rxlog, 1)
      `CHK(operating_width, `WIDTH_X4)
      `CHK(power_state_support, 2'h1)
      rd_chk(`LINK_CAP_ADDR, cap_word(`WIDTH_X4, 2'h1));
      // a reserved code is kept as written, port falls back to default
      port_mode <= port_loopback;
      wr_ok(`LINK_CAP_ADDR, cap_word(6'h03, `ASPM_RESET));
      wait_cyc(3);
      `CHK(n_retrain, 2)
      `CHK(operating_width, `WIDTH_X8)
      rd_chk(`LINK_CAP_ADDR, cap_word(6'h03, `ASPM_RESET));
      // low lane alone must not touch the width field or retrain
      axi_write(`LINK_CAP_ADDR, cap_word(`WIDTH_X1, `ASPM_RESET), 4'h1, r);
      `CHK(r, `RESP_OKAY)
      wait_cyc(3);
      `CHK(n_retrain, 2)
      rd_chk(`LINK_CAP_ADDR, cap_word(6'h03, `ASPM_RESET));
   endtask

   task automatic t_unmapped();
      word_type   d;
      logic [1:0] r;
      axi_write(14'h0100, 32'hffff_ffff, 4'hf, r);
      `CHK(r, `RESP_SLVERR)
      axi_read(14'h0100, d, r);
      `CHK(r, `RESP_SLVERR)
      `CHK(d, 32'h0000_0000)
   endtask

   initial begin
      n_fail = 0;
      checked = 0;
      cycles = 0;
      n_retrain = 0;
      n_rxlog = 0;
      aresetn = 1'b0;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      correctable_err_evt = 1'b0;
      nonfatal_err_evt = 1'b0;
      fatal_err_evt = 1'b0;
      unsupported_req_evt = 1'b0;
      strap_width = `WIDTH_X8;
      port_mode = port_disabled;
      phy_receiver_err = 1'b0;
      phy_retraining = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      // width default needs one edge to reach the field and two to reach operating_width
      repeat (3) @(posedge aclk);
      t_reset_values();
      t_events();
      t_w1c();
      t_irq();
      t_width();
      t_unmapped();
      give_verdict();
   end
endmodule
